// *** src/srw_exec.sv ***
// module: executes register read/write script instructions
// Function
// RULE_01: class 01 in bits 31-30 selects block
// RULE_02: opcodes 101, 110, 111 are register ops
// RULE_03: 101 writes register from first-byte operand
// RULE_04: 110 writes first-received-byte register
// RULE_05: 111 read-modify-writes the addressed register
// RULE_06: bit 24 enables stored carry-in
// RULE_07: carry only changed by add/set/clear
// RULE_08: bits 22-16 address the register
// RULE_09: immediate byte from bits 15-8
// RULE_10: second word is zero, ignored
// RULE_11: bits 7-0 and 23 kept zero
// RULE_12: same behaviour as initiator or target
// RULE_13: set/clear flag bit 10 drives carry
// RULE_14: no register write alters carry
// RULE_15: add truncates result, keeps carry-out
// RULE_16: next fetch follows the two words
//
// one instruction is offered per strobe; the block then runs three
// cycles: accept, register read, result write. the register file
// answers a read strobe with data in the following cycle only, so the
// arithmetic waits for that cycle before it forms the result.
// opcode 101 still issues a read, which keeps the timing the same for
// every register operation and lets the fetch side plan a fixed gap.
// set and clear instructions are watched only for the carry bit of
// their flags field; every other part of them belongs elsewhere.
// the second instruction word is accepted and left unread.
// the carry flag has no register write path at all, so software can
// move it only through add, set carry and clear carry.
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
module srw_exec
  import srw_pkg::*;
#(
  parameter int ADDR_W = 7
) (
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  input  wire logic              insn_valid_in,   // both words presented, one cycle
  input  wire logic [31:0]       insn_word0_in,
  input  wire logic [31:0]       insn_word1_in,   // ignored
  input  wire logic [31:0]       insn_addr_in,    // address of first word
  output logic                   insn_done_out,   // one-cycle pulse, three cycles after accept
  output logic [31:0]            next_fetch_out,
  output logic                   reg_rd_out,      // register file read strobe
  output logic [ADDR_W-1:0]      reg_addr_out,
  input  wire logic [7:0]        reg_rdata_in,    // valid the cycle after reg_rd_out
  output logic                   reg_wr_out,
  output logic [7:0]             reg_wdata_out,
  output logic [7:0]             frb_out,         // first_received_byte_reg
  output logic                   carry_out,
  output logic                   busy_out
);
  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (ADDR_W != ADDR_HI - ADDR_LO + 1) begin : g_bad_width
    $error("srw_exec: ADDR_W must match the address field");
  end
  // the field positions must leave an 8-bit immediate and a 2-bit operator
  if (IMM_HI - IMM_LO != 7) begin : g_bad_imm
    $error("srw_exec: immediate field must be eight bits");
  end
  if (OPR_HI - OPR_LO != 1) begin : g_bad_opr
    $error("srw_exec: operator field must be two bits");
  end
  if (OPC_HI - OPC_LO != 2) begin : g_bad_opc
    $error("srw_exec: opcode field must be three bits");
  end
  if (CLASS_HI - CLASS_LO != 1) begin : g_bad_class
    $error("srw_exec: class field must be two bits");
  end

  // ---------------------------------------------------------------
  // decode of the offered instruction
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SRW_IDLE, SRW_READ, SRW_WRITE} srw_state_t;
  srw_state_t state;
  logic [2:0]  opc;
  srw_oper_t   oper;
  logic        cin_en;
  logic [7:0]  imm;
  logic [31:0] seq_addr;
  wire         in_class  = insn_word0_in[CLASS_HI:CLASS_LO] == CLASS_RW_IO;          // RULE_01
  wire [2:0]   in_opc    = insn_word0_in[OPC_HI:OPC_LO];
  wire         is_regop  = in_class && (in_opc == OPC_FROM_FRB || in_opc == OPC_TO_FRB
                           || in_opc == OPC_RMW);                                    // RULE_02
  wire         is_setclr = in_class && (in_opc == OPC_IO_SET || in_opc == OPC_IO_CLR);
  wire         carry_flg = insn_word0_in[FLAG_CARRY];                                // RULE_13
  wire         accept    = insn_valid_in && state == SRW_IDLE;                       // RULE_12

  // ---------------------------------------------------------------
  // operand selection and the arithmetic unit
  // ---------------------------------------------------------------
  // opcode 101 pairs the immediate with the first-byte register, others with the register
  wire [7:0]   operand   = (opc == OPC_FROM_FRB) ? frb_out : reg_rdata_in;          // RULE_03 RULE_04 RULE_05
  wire         cin       = cin_en & carry_out;                                       // RULE_06
  wire [8:0]   sum       = {1'b0, imm} + {1'b0, operand} + {8'h00, cin};
  wire [7:0]   result    = (oper == SRW_MOVE) ? imm :
                           (oper == SRW_OR)   ? (imm | operand) :
                           (oper == SRW_AND)  ? (imm & operand) : sum[7:0];          // RULE_15
  wire         to_frb    = opc == OPC_TO_FRB;                                        // RULE_04

  // ---------------------------------------------------------------
  // sequencer: accept, read register, write result
  // ---------------------------------------------------------------
  // idle waits for an offer, read drives the strobe, write sees the data
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state <= SRW_IDLE;
      opc <= 3'h0;
      oper <= SRW_MOVE;
      cin_en <= 1'b0;
      imm <= 8'h00;
      seq_addr <= 32'h00000000;
      reg_addr_out <= '0;
    end else begin
      case (state)
        SRW_IDLE: begin
          if (accept && is_regop) begin
            opc <= in_opc;
            oper <= srw_oper_t'(insn_word0_in[OPR_HI:OPR_LO]);
            cin_en <= insn_word0_in[CARRY_EN_BIT];                                  // RULE_06
            imm <= insn_word0_in[IMM_HI:IMM_LO];                                     // RULE_09
            reg_addr_out <= insn_word0_in[ADDR_HI:ADDR_LO];                          // RULE_08
            seq_addr <= insn_addr_in + INSN_BYTES;                                   // RULE_16
            state <= SRW_READ;
          end
        end
        SRW_READ: begin
          state <= SRW_WRITE;
        end
        default: begin
          state <= SRW_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register file strobes and data
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      reg_rd_out <= 1'b0;
      reg_wr_out <= 1'b0;
      reg_wdata_out <= 8'h00;
    end else begin
      reg_rd_out <= accept && is_regop;
      reg_wr_out <= state == SRW_WRITE && !to_frb;                                   // RULE_03 RULE_05
      if (state == SRW_WRITE) begin
        reg_wdata_out <= result;
      end
    end
  end

  // ---------------------------------------------------------------
  // first-received-byte register and carry flag
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      frb_out <= FRB_RESET;
      carry_out <= CARRY_RESET;
    end else begin
      if (state == SRW_WRITE && to_frb) begin
        frb_out <= result;                                                           // RULE_04
      end
      // carry moves only on add or the set/clear flag; register writes never touch it
      if (state == SRW_WRITE && oper == SRW_ADD) begin
        carry_out <= sum[8];                                                         // RULE_07 RULE_15 RULE_14
      end else if (accept && is_setclr && carry_flg) begin
        carry_out <= in_opc == OPC_IO_SET;                                           // RULE_13
      end
    end
  end

  // ---------------------------------------------------------------
  // completion and next fetch address
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      insn_done_out <= 1'b0;
      next_fetch_out <= 32'h00000000;
      busy_out <= 1'b0;
    end else begin
      insn_done_out <= state == SRW_WRITE;
      if (state == SRW_WRITE) begin
        next_fetch_out <= seq_addr;                                                  // RULE_16
      end
      busy_out <= (accept && is_regop) || state == SRW_READ;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // an accepted op strobes the read, then completes once data stood
  a_read_after_accept: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_02
    accept && is_regop |=> reg_rd_out ##2 insn_done_out)
    else $error("register op did not read then complete");

  // move to the first-byte register never writes the register file
  a_frb_no_regwrite: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_04
    state == SRW_WRITE && to_frb |=> !reg_wr_out && frb_out == $past(result))
    else $error("move-to-frb wrote wrong place");

  // the other two opcodes write the result back to the register file
  a_write_value: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_05
    state == SRW_WRITE && !to_frb |=> reg_wr_out && reg_wdata_out == $past(result))
    else $error("register write wrong");

  // carry holds unless an add finishes or a set/clear names it
  a_carry_stable: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_07
    !(state == SRW_WRITE && oper == SRW_ADD) && !(accept && is_setclr && carry_flg)
    |=> $stable(carry_out))
    else $error("carry changed without cause");

  // an add leaves its ninth bit in the carry flag
  a_carry_add: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_15
    state == SRW_WRITE && oper == SRW_ADD |=> carry_out == $past(sum[8]))
    else $error("carry-out not captured");

  // set writes one, clear writes zero
  a_carry_setclr: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_13
    accept && is_setclr && carry_flg |=> carry_out == ($past(in_opc) == OPC_IO_SET))
    else $error("set/clear carry wrong");

  // the next fetch follows the two words of the instruction
  a_next_fetch: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_16
    accept && is_regop |-> ##3 next_fetch_out == $past(insn_addr_in, 3) + INSN_BYTES)
    else $error("next fetch not sequential");

  // the register address is taken from its field at accept
  a_addr_field: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_08
    accept && is_regop |=> reg_addr_out == $past(insn_word0_in[ADDR_HI:ADDR_LO]))
    else $error("register address wrong");

  // the immediate is taken from its field at accept
  a_imm_field: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_09
    accept && is_regop |=> imm == $past(insn_word0_in[IMM_HI:IMM_LO]))
    else $error("immediate byte wrong");

  // done lasts exactly one cycle
  a_done_single: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_16
    insn_done_out |=> !insn_done_out)
    else $error("done longer than one cycle");

  // the read strobe lasts exactly one cycle
  a_rd_single: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_05
    reg_rd_out |=> !reg_rd_out)
    else $error("read strobe longer than one cycle");

  // read and write strobes never overlap on the register file
  a_no_rd_wr: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_05
    !(reg_rd_out && reg_wr_out))
    else $error("read and write strobes together");

  // a register write only ever comes with completion
  a_wr_with_done: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_03
    reg_wr_out |-> insn_done_out)
    else $error("register write outside completion");

  // offers of other classes or opcodes start nothing
  a_foreign_ignored: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_01
    insn_valid_in && state == SRW_IDLE && !is_regop |=> !reg_rd_out && !busy_out)
    else $error("foreign instruction started an op");

  // an add without carry enable adds only the two bytes
  a_cin_off: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_06
    state == SRW_WRITE && oper == SRW_ADD && !cin_en |-> sum == 9'(imm) + 9'(operand))
    else $error("carry-in used while disabled");

  // the first-byte register moves only on its own opcode
  a_frb_hold: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_04
    !(state == SRW_WRITE && to_frb) |=> $stable(frb_out))
    else $error("first byte register changed");

  // nothing is accepted while an op is in flight
  a_refuse_busy: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_02
    busy_out |-> !accept)
    else $error("offer accepted while busy");

  // read and write go to the same register address
  a_addr_steady: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_05
    state == SRW_WRITE |-> $stable(reg_addr_out))
    else $error("register address moved mid-op");

  // move, or and and leave the carry alone
  a_carry_logic: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_14
    state == SRW_WRITE && oper != SRW_ADD |=> $stable(carry_out))
    else $error("logic op changed carry");

  // the address output moves only when a register op is accepted
  a_addr_hold: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_08
    !(accept && is_regop) |=> $stable(reg_addr_out))
    else $error("register address changed without op");

  // the fetch address moves only at completion
  a_fetch_hold: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_16
    state != SRW_WRITE |=> $stable(next_fetch_out))
    else $error("fetch address changed without op");

  // set and clear never start a register op
  a_setclr_quiet: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_13
    accept && is_setclr |=> !busy_out && !reg_rd_out)
    else $error("set/clear started a register op");

  // busy covers the read and write cycles, in either bus role
  a_busy_span: assert property (@(posedge clock_in) disable iff (rst_in) // RULE_12
    accept && is_regop |=> busy_out ##1 busy_out ##1 !busy_out)
    else $error("busy span wrong");
endmodule

// *** src/srw_pkg.sv ***
// package: constants for the script register read/write executor
package srw_pkg;
  // ---------------------------------------------------------------
  // instruction word fields
  // ---------------------------------------------------------------
  localparam int          CLASS_HI     = 31;
  localparam int          CLASS_LO     = 30;
  localparam logic [1:0]  CLASS_RW_IO  = 2'h1;
  localparam int          OPC_HI       = 29;
  localparam int          OPC_LO       = 27;
  localparam logic [2:0]  OPC_FROM_FRB = 3'h5;
  localparam logic [2:0]  OPC_TO_FRB   = 3'h6;
  localparam logic [2:0]  OPC_RMW      = 3'h7;
  localparam logic [2:0]  OPC_IO_SET   = 3'h3;
  localparam logic [2:0]  OPC_IO_CLR   = 3'h4;
  localparam int          OPR_HI       = 26;
  localparam int          OPR_LO       = 25;
  localparam int          CARRY_EN_BIT = 24;
  localparam int          ADDR_HI      = 22;
  localparam int          ADDR_LO      = 16;
  localparam int          IMM_HI       = 15;
  localparam int          IMM_LO       = 8;
  localparam int          FLAG_CARRY   = 10;
  // ---------------------------------------------------------------
  // operators and reset values
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SRW_MOVE, SRW_OR, SRW_AND, SRW_ADD} srw_oper_t;
  localparam logic [7:0]  FRB_RESET    = 8'h00;
  localparam logic        CARRY_RESET  = 1'b0;
  localparam logic [31:0] INSN_BYTES   = 32'h00000008;
endpackage

// *** verification/srw_regfile_model.sv ***
// register file model that stands behind the register read/write executor
`timescale 1ns/100ps
module srw_regfile_model (
  input  wire logic       clock_in,
  input  wire logic       rd_in,
  input  wire logic [6:0] addr_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out
);
  logic [7:0] mem [128];
  // ---------------------------------------------------------------
  // storage, preset to a spread of values
  // ---------------------------------------------------------------
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i * 37 + 90);
    end
    rdata_out = 8'h00;
  end
  // read data stands one cycle only; otherwise it toggles, so stale data shows
  always @(posedge clock_in) begin
    if (rd_in) begin
      rdata_out <= mem[addr_in];
    end else begin
      rdata_out <= ~rdata_out;
    end
    if (wr_in) begin
      mem[addr_in] <= wdata_in;
    end
  end
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the register read/write executor
`timescale 1ns/100ps
module testbench;
  import srw_pkg::*;
  logic        clock_in, rst_in, insn_valid_in, insn_done_out;
  logic        reg_rd_out, reg_wr_out, carry_out, busy_out, exp_carry;
  logic [31:0] insn_word0_in, insn_word1_in, insn_addr_in, next_fetch_out;
  logic [6:0]  reg_addr_out;
  logic [7:0]  reg_rdata_in, reg_wdata_out, frb_out, exp_frb, x, res;
  logic [8:0]  sum;
  int          n_fail, num_checks;
  // ---------------------------------------------------------------
  // design and register file
  // ---------------------------------------------------------------
  srw_exec #(.ADDR_W(7)) u_dut (.clock_in(clock_in), .rst_in(rst_in),
    .insn_valid_in(insn_valid_in), .insn_word0_in(insn_word0_in),
    .insn_word1_in(insn_word1_in), .insn_addr_in(insn_addr_in),
    .insn_done_out(insn_done_out), .next_fetch_out(next_fetch_out),
    .reg_rd_out(reg_rd_out), .reg_addr_out(reg_addr_out), .reg_rdata_in(reg_rdata_in),
    .reg_wr_out(reg_wr_out), .reg_wdata_out(reg_wdata_out), .frb_out(frb_out),
    .carry_out(carry_out), .busy_out(busy_out));
  srw_regfile_model u_rf (.clock_in(clock_in), .rd_in(reg_rd_out), .addr_in(reg_addr_out),
    .wr_in(reg_wr_out), .wdata_in(reg_wdata_out), .rdata_out(reg_rdata_in));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    num_checks++;
    if (seen !== expv) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // present one instruction for one cycle
  task automatic issue(input logic [31:0] w);
    @(posedge clock_in);
    insn_valid_in <= 1'b1;
    insn_word0_in <= w;
    insn_addr_in  <= insn_addr_in + 32'h8;
    @(posedge clock_in);
    insn_valid_in <= 1'b0;
  endtask
  // run one register operation and compare with the worked-out result
  task automatic run_op(input logic [2:0] opc, input logic [1:0] opr, input logic cen,
                        input logic [6:0] a, input logic [7:0] imm);
    int k;
    issue({2'b01, opc, opr, cen, 1'b0, a, imm, 8'h00});
    x = (opc == OPC_FROM_FRB) ? exp_frb : u_rf.mem[a];
    case (opr)
      SRW_MOVE: res = imm;
      SRW_OR:   res = imm | x;
      SRW_AND:  res = imm & x;
      default: begin
        sum = 9'(imm) + 9'(x) + 9'(cen & exp_carry);
        res = sum[7:0];
        exp_carry = sum[8];
      end
    endcase
    #1;
    check(busy_out, 1'b1);
    for (k = 0; k < 4 && insn_done_out !== 1'b1; k++) begin
      @(posedge clock_in);
      #1;
    end
    check(insn_done_out, 1'b1);
    check(busy_out, 1'b0);
    check(reg_wr_out, opc != OPC_TO_FRB);
    if (opc == OPC_TO_FRB) begin
      exp_frb = res;
    end else begin
      check(reg_wdata_out, res);
    end
    check(frb_out, exp_frb);
    check(carry_out, exp_carry);
    check(reg_addr_out, a);
    check(next_fetch_out, insn_addr_in + 32'h8);
  endtask
  // flag or foreign instruction: no completion, carry as given
  task automatic flag_op(input logic [31:0] w, input logic expc);
    issue(w);
    @(posedge clock_in);
    #1;
    check(insn_done_out, 1'b0);
    check(carry_out, expc);
    check(frb_out, exp_frb);
    exp_carry = expc;
  endtask
  // ---------------------------------------------------------------
  // clock, watchdog and test sequence
  // ---------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  initial begin
    repeat (3000) @(posedge clock_in);
    n_fail++;
    give_verdict();
  end
  initial begin
    rst_in = 1'b1;
    insn_valid_in = 1'b0;
    insn_word0_in = 32'h0;
    insn_word1_in = 32'h0;
    insn_addr_in = 32'h00000FF8;
    exp_frb = FRB_RESET;
    exp_carry = CARRY_RESET;
    n_fail = 0;
    num_checks = 0;
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    #1;
    check(frb_out, FRB_RESET);
    check(carry_out, CARRY_RESET);
    flag_op(32'h58000400, 1'b1);
    for (int i = 0; i < 24; i++) begin
      run_op(3'(5 + i / 8), 2'(i / 2), 1'(i), 7'(i * 11), 8'(8'hC7 + i * 53));
    end
    flag_op(32'h60000400, 1'b0);
    flag_op(32'h58000400, 1'b1);
    flag_op(32'h98000400, 1'b1);
    run_op(OPC_RMW, SRW_ADD, 1'b1, 7'h7F, 8'hFF);
    give_verdict();
  end
endmodule
